// ===== logic/i2cs_pkg.sv
// Constants, register map and types for the I2C slave port
package i2cs_pkg;

    // Register bus geometry
    localparam int AW = 6;
    localparam int DW = 16;
    localparam int ID_COUNT = 4;

    // Register byte offsets
    localparam logic [AW-1:0] OFS_CTRL = 6'h00;
    localparam logic [AW-1:0] OFS_STAT = 6'h04;
    localparam logic [AW-1:0] OFS_MASK = 6'h08;
    localparam logic [AW-1:0] OFS_ID [ID_COUNT] = '{6'h0C, 6'h10, 6'h14, 6'h18};
    localparam logic [AW-1:0] OFS_ALT  = 6'h1C;
    localparam logic [AW-1:0] OFS_TXD  = 6'h20;
    localparam logic [AW-1:0] OFS_RXD  = 6'h24;

    // Control bit positions
    localparam int CB_SLV_EN  = 0;
    localparam int CB_TEN_BIT = 1;
    localparam int CB_GC_EN   = 2;
    localparam int CB_HGC_EN  = 3;
    localparam int CB_GC_CLR  = 4;
    localparam int CB_EARLY   = 5;
    localparam int CB_REFUSE_NEXT_TRANSFER    = 7;
    localparam int CB_IE_STOP = 8;
    localparam int CB_IE_RX   = 9;
    localparam int CB_IE_TX   = 10;

    // Reset and write masks
    localparam logic [DW-1:0] CTRL_RST   = 16'h0000;
    localparam logic [DW-1:0] CTRL_WMASK = 16'h07EF;
    localparam logic [DW-1:0] MASK_RST   = 16'hFFFF;
    localparam logic [7:0]    BYTE_RST   = 8'h00;

    // Bus codes
    localparam logic [7:0] GC_ADDR       = 8'h00;
    localparam logic [7:0] GC_RESET_BYTE = 8'h06;
    localparam logic [7:0] GC_PROG_BYTE  = 8'h04;
    localparam logic [4:0] TEN_PREFIX    = 5'h1E;
    localparam int         TEN_PAIR      = 2;

    // General call kinds
    localparam logic [1:0] GCK_NONE  = 2'h0;
    localparam logic [1:0] GCK_RESET = 2'h1;
    localparam logic [1:0] GCK_PROG  = 2'h2;
    localparam logic [1:0] GCK_HW    = 2'h3;

    // Bit counting
    localparam logic [3:0] CNT_ZERO  = 4'h0;
    localparam logic [3:0] CNT_ONE   = 4'h1;
    localparam logic [3:0] CNT_LAST  = 4'h7;
    localparam logic [3:0] CNT_BYTE  = 4'h8;

    // Status register layout
    typedef struct packed {
        logic [2:0] rsvd_hi;
        logic [1:0] id_match;
        logic       stop_seen;
        logic [1:0] general_call_kind;
        logic       general_call_flag;
        logic       busy;
        logic       noack;
        logic       rsvd_mid;
        logic       slave_rx_request_flag;
        logic       slave_tx_request_flag;
        logic [1:0] rsvd_lo;
    } i2cs_stat_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_ADDR2, ST_ADDR2_ACK,
        ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK
    } i2cs_state_t;

endpackage : i2cs_pkg

// ===== logic/i2cs_slave.sv
// I2C slave port with control register, address match and interrupt
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Control bit 10 gates the transmit request onto the interrupt.
// - Control bit 9 gates the receive request onto the interrupt.
// - Control bit 8 gates stop detection onto the interrupt.
// - While bit 7 is set, the next addressed transfer gets a not-acknowledge.
// - Early mode raises transmit request after SCL rise of the direction bit.
// - Writing one to bit 4 clears general call flag and kind; not stored.
// - General call flag and kind hold until that clear or full reset.
// - Bits 3 and 2 set: byte after address 00h compared with backup id.
// - Bit 2 set acknowledges general call 00h write; clear refuses it.
// - Bit 1 clear: four independent 7-bit addresses from four id registers.
// - Ten-bit mode matches one address from id 0 and id 1 (11110 prefix).
// - Ten-bit mode still matches 7-bit addresses in id 2 and id 3.
// - Bit 0 clear holds protocol state and busy in reset; other status flags keep; bus ignored.
// - Normal mode raises transmit request on SCL fall of direction bit.
// - Stop after start and matching address sets stop flag; status read clears.
// - General call kind cleared only by bit 4 or full reset, not by general call reset.
module i2cs_slave
    import i2cs_pkg::*;
(
    // Clock, reset, enable
    input  wire logic          REF_CLK,
    input  wire logic          RESETN,
    input  wire logic          CE,
    // Register port
    input  wire logic [AW-1:0] ADDR,
    input  wire logic [DW-1:0] WDATA,
    input  wire logic          WR,
    input  wire logic          RD,
    output logic      [DW-1:0] RDATA,
    // I2C pins
    input  wire logic          SCL_PIN,
    input  wire logic          SDA_PIN,
    output logic               SDA_LEVEL,
    output logic               SDA_OE,
    // Interrupt
    output logic               IRQ
);

    // Pin synchronisers
    logic              scl_m_r, scl_s_r, scl_d_r;
    logic              sda_m_r, sda_s_r, sda_d_r;
    logic              scl_rise, scl_fall, start_ev, stop_ev;

    // Registers and protocol state
    logic [DW-1:0]     ctrl_r, ctrl_nxt;
    logic [DW-1:0]     mask_r, mask_nxt;
    i2cs_stat_t        stat_r, stat_nxt;
    logic [7:0]        id_r [ID_COUNT];
    logic [7:0]        id_nxt [ID_COUNT];
    logic [7:0]        alt_r, alt_nxt;
    logic [7:0]        txd_r, txd_nxt;
    logic [7:0]        rxd_r, rxd_nxt;
    logic [DW-1:0]     rdata_r, rdata_nxt;
    i2cs_state_t       state_r, state_nxt;
    i2cs_state_t       after_r, after_nxt;
    logic [3:0]        cnt_r, cnt_nxt;
    logic [7:0]        shift_r, shift_nxt;
    logic              drive_r, drive_nxt;
    logic              ten_hit_r, ten_hit_nxt;
    logic              gc_mode_r, gc_mode_nxt;

    // Address matching
    logic [7:0]        mbyte;
    logic [ID_COUNT-1:0] id_hit;
    logic              any_hit, ten_first, is_gc, rw_read;
    logic [1:0]        hit_idx;
    i2cs_stat_t        irq_en;

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else if (CE) begin
            scl_m_r <= SCL_PIN;
            scl_s_r <= scl_m_r;
            scl_d_r <= scl_s_r;
            sda_m_r <= SDA_PIN;
            sda_s_r <= sda_m_r;
            sda_d_r <= sda_s_r;
        end
    end

    assign scl_rise = scl_s_r & ~scl_d_r;
    assign scl_fall = ~scl_s_r & scl_d_r;
    assign start_ev = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
    assign stop_ev  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

    // Byte under test: incoming bit joined in on a rising edge
    assign mbyte   = scl_rise ? {shift_r[6:0], sda_s_r} : shift_r;
    assign rw_read = mbyte[0];

    genvar g;
    generate
        for (g = 0; g < ID_COUNT; g++) begin : g_match
            assign id_hit[g] = (mbyte[7:1] == id_r[g][7:1]) && !(ctrl_r[CB_TEN_BIT] && (g < TEN_PAIR));
        end
    endgenerate

    assign ten_first = ctrl_r[CB_TEN_BIT] && (mbyte[7:3] == TEN_PREFIX) && (mbyte[7:1] == id_r[0][7:1]);
    assign is_gc     = (mbyte == GC_ADDR);
    assign any_hit   = |id_hit;

    always_comb begin
        hit_idx = 2'h0;
        for (int i = ID_COUNT - 1; i >= 0; i--) begin
            if (id_hit[i]) begin
                hit_idx = 2'(i);
            end
        end
    end

    always_comb begin
        irq_en                       = '0;
        irq_en.stop_seen             = ctrl_r[CB_IE_STOP];
        irq_en.slave_rx_request_flag = ctrl_r[CB_IE_RX];
        irq_en.slave_tx_request_flag = ctrl_r[CB_IE_TX];
        irq_en.general_call_flag     = 1'b1;
    end
    assign IRQ = |(stat_r & mask_r & irq_en);

    always_comb begin
        ctrl_nxt    = ctrl_r;
        mask_nxt    = mask_r;
        stat_nxt    = stat_r;
        id_nxt      = id_r;
        alt_nxt     = alt_r;
        txd_nxt     = txd_r;
        rxd_nxt     = rxd_r;
        rdata_nxt   = '0;
        state_nxt   = state_r;
        after_nxt   = after_r;
        cnt_nxt     = cnt_r;
        shift_nxt   = shift_r;
        drive_nxt   = drive_r;
        ten_hit_nxt = ten_hit_r;
        gc_mode_nxt = gc_mode_r;

        // Register writes
        if (WR) begin
            if (ADDR == OFS_CTRL) begin
                ctrl_nxt = WDATA & CTRL_WMASK;
                if (WDATA[CB_GC_CLR]) begin
                    stat_nxt.general_call_flag = 1'b0;
                    stat_nxt.general_call_kind = GCK_NONE;
                end
            end
            if (ADDR == OFS_MASK) begin
                mask_nxt = WDATA;
            end
            if (ADDR == OFS_ALT) begin
                alt_nxt = WDATA[7:0];
            end
            if (ADDR == OFS_TXD) begin
                txd_nxt = WDATA[7:0];
            end
            for (int i = 0; i < ID_COUNT; i++) begin
                if (ADDR == OFS_ID[i]) begin
                    id_nxt[i] = WDATA[7:0];
                end
            end
        end

        // Register reads; status read clears stop, noack and tx request flags
        if (RD) begin
            case (ADDR)
                OFS_CTRL: rdata_nxt = ctrl_r;
                OFS_STAT: begin
                    rdata_nxt = stat_r;
                    stat_nxt.stop_seen = 1'b0;
                    stat_nxt.noack = 1'b0;
                    stat_nxt.slave_tx_request_flag = 1'b0;
                end
                OFS_MASK: rdata_nxt = mask_r;
                OFS_ALT:  rdata_nxt = {8'h00, alt_r};
                OFS_TXD:  rdata_nxt = {8'h00, txd_r};
                OFS_RXD: begin
                    rdata_nxt = {8'h00, rxd_r};
                    stat_nxt.slave_rx_request_flag = 1'b0;
                end
                default: begin
                    for (int i = 0; i < ID_COUNT; i++) begin
                        if (ADDR == OFS_ID[i]) begin
                            rdata_nxt = {8'h00, id_r[i]};
                        end
                    end
                end
            endcase
        end

        // slave held in reset while disabled
        if (!ctrl_r[CB_SLV_EN]) begin
            state_nxt   = ST_IDLE;
            after_nxt   = ST_IDLE;
            cnt_nxt     = CNT_ZERO;
            shift_nxt   = BYTE_RST;
            drive_nxt   = 1'b0;
            ten_hit_nxt = 1'b0;
            gc_mode_nxt = 1'b0;
            stat_nxt.busy = 1'b0;
        end else if (stop_ev) begin
            if (stat_r.busy) begin
                stat_nxt.stop_seen = 1'b1;
            end
            stat_nxt.busy = 1'b0;
            state_nxt     = ST_IDLE;
            drive_nxt     = 1'b0;
            ten_hit_nxt   = 1'b0;
        end else if (start_ev) begin
            state_nxt     = ST_ADDR;
            cnt_nxt       = CNT_ZERO;
            drive_nxt     = 1'b0;
            gc_mode_nxt   = 1'b0;
            stat_nxt.busy = 1'b1;
        end else if (scl_rise) begin
            case (state_r)
                ST_ADDR, ST_ADDR2, ST_RX: begin
                    shift_nxt = mbyte;
                    cnt_nxt   = cnt_r + CNT_ONE;
                    if (state_r == ST_ADDR && cnt_r == CNT_LAST && ctrl_r[CB_EARLY] && rw_read
                        && (any_hit || (ten_first && ten_hit_r))) begin
                        stat_nxt.slave_tx_request_flag = 1'b1;
                    end
                end
                ST_TX_ACK: shift_nxt[0] = sda_s_r;
                default: ;
            endcase
        end else if (scl_fall) begin
            case (state_r)
                ST_ADDR: begin
                    if (cnt_r == CNT_BYTE) begin
                        state_nxt = ST_IDLE;
                        if (is_gc) begin
                            if (ctrl_r[CB_GC_EN]) begin
                                state_nxt   = ST_ADDR_ACK;
                                after_nxt   = ST_RX;
                                gc_mode_nxt = 1'b1;
                            end
                        end else if (ten_first) begin
                            if (!rw_read) begin
                                state_nxt = ST_ADDR_ACK;
                                after_nxt = ST_ADDR2;
                            end else if (ten_hit_r) begin
                                state_nxt = ST_ADDR_ACK;
                                after_nxt = ST_TX;
                            end
                        end else if (any_hit) begin
                            state_nxt = ST_ADDR_ACK;
                            after_nxt = rw_read ? ST_TX : ST_RX;
                            stat_nxt.id_match = hit_idx;
                        end
                        if (state_nxt == ST_IDLE) begin
                            stat_nxt.busy = 1'b0;
                        end else if (ctrl_r[CB_REFUSE_NEXT_TRANSFER]) begin
                            state_nxt      = ST_IDLE;
                            stat_nxt.noack = 1'b1;
                        end else begin
                            drive_nxt = 1'b1;
                            if (rw_read && !ctrl_r[CB_EARLY]) begin
                                stat_nxt.slave_tx_request_flag = 1'b1;
                            end
                        end
                    end
                end
                ST_ADDR2: begin
                    if (cnt_r == CNT_BYTE) begin
                        if (shift_r == id_r[1] && !ctrl_r[CB_REFUSE_NEXT_TRANSFER]) begin
                            state_nxt   = ST_ADDR2_ACK;
                            drive_nxt   = 1'b1;
                            ten_hit_nxt = 1'b1;
                            stat_nxt.id_match = 2'h0;
                        end else begin
                            state_nxt      = ST_IDLE;
                            stat_nxt.busy  = 1'b0;
                            if (ctrl_r[CB_REFUSE_NEXT_TRANSFER] && shift_r == id_r[1]) begin
                                stat_nxt.noack = 1'b1;
                            end
                        end
                    end
                end
                ST_ADDR_ACK, ST_ADDR2_ACK, ST_RX_ACK: begin
                    cnt_nxt   = CNT_ZERO;
                    drive_nxt = 1'b0;
                    state_nxt = (state_r == ST_ADDR_ACK) ? after_r : ST_RX;
                    if (state_r == ST_ADDR_ACK && after_r == ST_TX) begin
                        shift_nxt = txd_r;
                        drive_nxt = ~txd_r[7];
                    end
                end
                ST_RX: begin
                    if (cnt_r == CNT_BYTE) begin
                        rxd_nxt = shift_r;
                        stat_nxt.slave_rx_request_flag = 1'b1;
                        if (gc_mode_r) begin
                            gc_mode_nxt = 1'b0;
                            stat_nxt.general_call_flag = 1'b1;
                            if (ctrl_r[CB_HGC_EN] && shift_r == alt_r) begin
                                stat_nxt.general_call_kind = GCK_HW;
                            end else if (shift_r == GC_RESET_BYTE) begin
                                stat_nxt.general_call_kind = GCK_RESET;
                            end else if (shift_r == GC_PROG_BYTE) begin
                                stat_nxt.general_call_kind = GCK_PROG;
                            end
                        end
                        state_nxt = ST_RX_ACK;
                        drive_nxt = 1'b1;
                    end
                end
                ST_TX: begin
                    cnt_nxt = cnt_r + CNT_ONE;
                    if (cnt_r == CNT_LAST) begin
                        state_nxt = ST_TX_ACK;
                        drive_nxt = 1'b0;
                    end else begin
                        shift_nxt = {shift_r[6:0], 1'b0};
                        drive_nxt = ~shift_r[6];
                    end
                end
                ST_TX_ACK: begin
                    cnt_nxt = CNT_ZERO;
                    if (!shift_r[0]) begin
                        state_nxt = ST_TX;
                        shift_nxt = txd_r;
                        drive_nxt = ~txd_r[7];
                        stat_nxt.slave_tx_request_flag = 1'b1;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
                default: state_nxt = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_r    <= CTRL_RST;
            mask_r    <= MASK_RST;
            stat_r    <= '0;
            id_r      <= '{default: BYTE_RST};
            alt_r     <= BYTE_RST;
            txd_r     <= BYTE_RST;
            rxd_r     <= BYTE_RST;
            rdata_r   <= '0;
            state_r   <= ST_IDLE;
            after_r   <= ST_IDLE;
            cnt_r     <= CNT_ZERO;
            shift_r   <= BYTE_RST;
            drive_r   <= 1'b0;
            ten_hit_r <= 1'b0;
            gc_mode_r <= 1'b0;
        end else if (CE) begin
            ctrl_r    <= ctrl_nxt;
            mask_r    <= mask_nxt;
            stat_r    <= stat_nxt;
            id_r      <= id_nxt;
            alt_r     <= alt_nxt;
            txd_r     <= txd_nxt;
            rxd_r     <= rxd_nxt;
            rdata_r   <= rdata_nxt;
            state_r   <= state_nxt;
            after_r   <= after_nxt;
            cnt_r     <= cnt_nxt;
            shift_r   <= shift_nxt;
            drive_r   <= drive_nxt;
            ten_hit_r <= ten_hit_nxt;
            gc_mode_r <= gc_mode_nxt;
        end
    end

    assign RDATA  = rdata_r;
    assign SDA_LEVEL = 1'b0;
    assign SDA_OE = drive_r;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);

    AST_TX_IRQ_GATE: assert property (stat_r.slave_tx_request_flag && mask_r[2] && !ctrl_r[CB_IE_TX]
        && !(stat_r[3] && ctrl_r[CB_IE_RX]) && !(stat_r.stop_seen && ctrl_r[CB_IE_STOP])
        && !stat_r.general_call_flag |-> !IRQ) else $error("tx request raised irq while disabled");
    AST_RX_IRQ: assert property (stat_r.slave_rx_request_flag && mask_r[3] && ctrl_r[CB_IE_RX]
        |-> IRQ) else $error("enabled rx request gave no irq");
    AST_STOP_IRQ: assert property (stat_r.stop_seen && mask_r[10] && ctrl_r[CB_IE_STOP] |-> IRQ)
        else $error("enabled stop gave no irq");
    AST_REFUSE: assert property (CE && scl_fall && state_r == ST_ADDR && cnt_r == CNT_BYTE && ctrl_r[CB_REFUSE_NEXT_TRANSFER]
        && ctrl_r[CB_SLV_EN] && !stop_ev && !start_ev |=> !SDA_OE && state_r == ST_IDLE)
        else $error("refused transfer was acknowledged");
    AST_EARLY_TX: assert property (CE && ctrl_r[CB_SLV_EN] && ctrl_r[CB_EARLY] && !stop_ev && !start_ev
        && scl_rise && state_r == ST_ADDR && cnt_r == CNT_LAST && rw_read && any_hit
        |=> stat_r.slave_tx_request_flag) else $error("early tx request missing");
    AST_GC_CLEAR: assert property (CE && WR && ADDR == OFS_CTRL && WDATA[CB_GC_CLR]
        && !(scl_fall && state_r == ST_RX && gc_mode_r) |=> !stat_r.general_call_flag
        && stat_r.general_call_kind == GCK_NONE && !ctrl_r[CB_GC_CLR]) else $error("general call clear failed");
    AST_GC_HOLD: assert property ($fell(stat_r.general_call_flag) |-> $past(WR && ADDR == OFS_CTRL
        && WDATA[CB_GC_CLR])) else $error("general call flag lost without clear");
    AST_GC_REFUSED: assert property (CE && ctrl_r[CB_SLV_EN] && !ctrl_r[CB_GC_EN] && scl_fall && !stop_ev
        && !start_ev && state_r == ST_ADDR && cnt_r == CNT_BYTE && is_gc |=> !SDA_OE [*2])
        else $error("general call acknowledged while disabled");
    AST_DISABLED: assert property (CE && !ctrl_r[CB_SLV_EN] |=> state_r == ST_IDLE && !SDA_OE)
        else $error("slave active while disabled");
    AST_IRQ_CAUSE: assert property (IRQ |-> (stat_r.general_call_flag && mask_r[7])
        || (stat_r.slave_tx_request_flag && mask_r[2] && ctrl_r[CB_IE_TX])
        || (stat_r.slave_rx_request_flag && mask_r[3] && ctrl_r[CB_IE_RX])
        || (stat_r.stop_seen && mask_r[10] && ctrl_r[CB_IE_STOP]))
        else $error("irq without enabled source");

    COV_ADDR_ACK: cover property (state_r == ST_ADDR_ACK ##1 SDA_OE);
    COV_TX_BYTE: cover property (state_r == ST_TX_ACK);
    COV_GC: cover property ($rose(stat_r.general_call_flag));
    COV_STOP: cover property ($rose(stat_r.stop_seen));

endmodule : i2cs_slave

`default_nettype wire

// ===== dv/i2cs_master_model.sv
// I2C master model for the slave port bench
`timescale 1ns/1ps
`default_nettype none
module i2cs_master_model (
    // Bus lines
    input  wire logic sda_oe,
    output var logic  scl,
    output wire logic sda
);
    logic drv_low = 1'b0;
    initial scl = 1'b1;
    // Open drain, pulled up when released
    assign sda = ~(drv_low | sda_oe);
    task automatic start_c;
        #200 drv_low = 1'b1;
        #200 scl = 1'b0;
    endtask : start_c
    task automatic stop_c;
        #50 drv_low = 1'b1;
        #150 scl = 1'b1;
        #200 drv_low = 1'b0;
        #400;
    endtask : stop_c
    // Nine bits MSB first; line sampled late in each high phase
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            #50 drv_low = ~d[i];
            #150 scl = 1'b1;
            #150 q[i] = sda;
            #50 scl = 1'b0;
        end
    endtask : xfer
endmodule : i2cs_master_model
`default_nettype wire

// ===== dv/i2cs_slave_bench.sv
// Self-checking bench for the I2C slave port
`timescale 1ns/1ps
`default_nettype none
module i2cs_slave_bench;
    import i2cs_pkg::*;
    localparam logic [15:0] EMD [2] = '{16'h0401, 16'h0421};
    localparam logic [15:0] REF [3] = '{16'h0081, 16'h0000, 16'h0001};
    localparam logic [7:0]  RAD [3] = '{8'h84, 8'h84, 8'h00};
    localparam logic [7:0]  GCB [3] = '{8'h06, 8'h04, 8'h85};
    localparam logic [15:0] GCE [3] = '{16'h0180, 16'h0280, 16'h0380};
    logic          clk = 1'b0;
    logic          rst_n = 1'b0;
    logic [AW-1:0] addr = '0;
    logic [DW-1:0] wdata = '0;
    logic          wr = 1'b0;
    logic          rd = 1'b0;
    logic [DW-1:0] rdata;
    logic          oe;
    logic          irq;
    logic [8:0]    q;
    wire logic     scl;
    wire logic     sda;
    int            fails = 0;
    int            check_count = 0;
    int            cycles = 0;
    i2cs_slave dut_u (.REF_CLK(clk), .RESETN(rst_n), .CE(1'b1), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .SCL_PIN(scl), .SDA_PIN(sda), .SDA_LEVEL(), .SDA_OE(oe), .IRQ(irq));
    i2cs_master_model m_u (.sda_oe(oe), .scl(scl), .sda(sda));
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            finish_test();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [AW-1:0] a, input logic [DW-1:0] m, input logic [DW-1:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata & m, e);
    endtask : rd_reg
    task automatic byt(input logic [7:0] d, input logic ea);
        m_u.xfer({d, 1'b1}, q);
        chk(16'(q[0]), 16'(ea));
    endtask : byt
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(OFS_CTRL, 16'hFFFF, 16'h0000);
        rd_reg(OFS_MASK, 16'hFFFF, 16'hFFFF);
        wr_reg(OFS_CTRL, 16'h07BF);
        rd_reg(OFS_CTRL, 16'hFFFF, 16'h07AF);
        // Write to the third address
        wr_reg(OFS_ID[2], 16'h0084);
        wr_reg(OFS_TXD, 16'h00C3);
        wr_reg(OFS_CTRL, 16'h0301);
        m_u.start_c();
        byt(8'h84, 1'b0);
        byt(8'hA5, 1'b0);
        m_u.stop_c();
        chk(16'(irq), 16'h0001);
        wr_reg(OFS_MASK, 16'h0000);
        chk(16'(irq), 16'h0000);
        wr_reg(OFS_MASK, 16'hFFFF);
        rd_reg(OFS_STAT, 16'h1C08, 16'h1408);
        chk(16'(irq), 16'h0001);
        rd_reg(OFS_RXD, 16'h00FF, 16'h00A5);
        chk(16'(irq), 16'h0000);
        // Reads in normal and early request mode
        foreach (EMD[i]) begin
            wr_reg(OFS_CTRL, EMD[i]);
            m_u.start_c();
            fork
                m_u.xfer(9'h10B, q);
                #3340 chk(16'(irq), 16'(EMD[i][5]));
            join
            chk(16'(q[0]), 16'h0000);
            m_u.xfer(9'h1FF, q);
            chk(16'(q[8:1]), 16'h00C3);
            m_u.stop_c();
            chk(16'(irq), 16'h0001);
            wr_reg(OFS_CTRL, 16'h0001);
            chk(16'(irq), 16'h0000);
            rd_reg(OFS_STAT, 16'h0004, 16'h0004);
        end
        // Refused addresses
        foreach (REF[i]) begin
            wr_reg(OFS_CTRL, REF[i]);
            m_u.start_c();
            byt(RAD[i], 1'b1);
            m_u.stop_c();
        end
        rd_reg(OFS_STAT, 16'h0020, 16'h0020);
        wr_reg(OFS_ALT, 16'h0085);
        foreach (GCB[i]) begin
            wr_reg(OFS_CTRL, 16'h000D);
            m_u.start_c();
            byt(8'h00, 1'b0);
            byt(GCB[i], 1'b0);
            m_u.stop_c();
            chk(16'(irq), 16'h0001);
            rd_reg(OFS_STAT, 16'h0380, GCE[i]);
            rd_reg(OFS_STAT, 16'h0380, GCE[i]);
            wr_reg(OFS_CTRL, 16'h001D);
            rd_reg(OFS_STAT, 16'h0380, 16'h0000);
            chk(16'(irq), 16'h0000);
        end
        // Ten-bit address beside a seven-bit one
        wr_reg(OFS_ID[0], 16'h00F2);
        wr_reg(OFS_ID[1], 16'h0034);
        wr_reg(OFS_CTRL, 16'h0003);
        m_u.start_c();
        byt(8'hF2, 1'b0);
        byt(8'h34, 1'b0);
        byt(8'h5A, 1'b0);
        m_u.stop_c();
        rd_reg(OFS_RXD, 16'h00FF, 16'h005A);
        m_u.start_c();
        byt(8'h84, 1'b0);
        m_u.stop_c();
        finish_test();
    end
endmodule : i2cs_slave_bench
`default_nettype wire
